// *** rtl/fspr_consts.svh ***
`ifndef FSPR_CONSTS_SVH
`define FSPR_CONSTS_SVH

// ***********************************************
// Register byte addresses
// ***********************************************
`define FSPR_ADDR_MODE_CTRL 20'hf02c0
`define FSPR_ADDR_SEQ_CTRL 20'hf02c5
`define FSPR_ADDR_END_LOW 20'hf02c6
`define FSPR_ADDR_END_HIGH 20'hf02c8
`define FSPR_ADDR_WBUF_LOW 20'hf02cc
`define FSPR_ADDR_WBUF_HIGH 20'hf02ce

// ***********************************************
// Reset values
// ***********************************************
`define FSPR_RST_MODE_CTRL 8'h08
`define FSPR_RST_SEQ_CTRL 8'h00
`define FSPR_RST_END_LOW 16'h0000
`define FSPR_RST_END_HIGH 4'h0
`define FSPR_RST_WBUF 16'h0000

// ***********************************************
// Mode control fields
// ***********************************************
`define FSPR_MODE_CODE_BIT 1
`define FSPR_MODE_INHIBIT_BIT 3
`define FSPR_MODE_DATA_BIT 4
`define FSPR_MODE_WR_MASK 8'h1a

// ***********************************************
// Sequencer control fields
// ***********************************************
`define FSPR_SEQ_START_BIT 7
`define FSPR_SEQ_STOP_BIT 6
`define FSPR_SEQ_AREA_BIT 3
`define FSPR_SEQ_CMD_MSB 2
`define FSPR_SEQ_WR_MASK 8'hcf

// ***********************************************
// End address layout
// ***********************************************
`define FSPR_END_HIGH_MSB 3
`define FSPR_CODE_ALIGN_BITS 2

`endif

// *** rtl/fspr_pkg.sv ***
package fspr_pkg;

  // CPU access, one per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } fspr_cpu_req_t;

  // Command handed to the sequencer
  typedef struct packed {
    logic start;
    logic stop;
    logic area;
    logic [2:0] cmd;
  } fspr_seq_cmd_t;

  // Programming controls seen by the flash core
  typedef struct packed {
    logic codeProgEnable;
    logic dataProgEnable;
    logic [19:0] endAddr;
    logic [31:0] progData;
  } fspr_prog_t;

  typedef enum logic [1:0] {
    FSPR_SEQ_IDLE = 2'b01,
    FSPR_SEQ_BUSY = 2'b10
  } fspr_seq_state_t;

endpackage

// *** rtl/fspr_regif.sv ***
`timescale 1ns/100ps
`include "fspr_consts.svh"

// Summary of operation
// R1: Buffer and end address writable only in program mode
// R2: Software touches them only with sequencers stopped
// R3: Buffer halves accessed as whole 16-bit words
// R4: Buffer cleared on reset, soft reset, finish
// R5: Data flash byte in low eight bits
// R6: High half bits 31-16, low half 15-0
// R7: Bit 4 selects data flash programming mode
// R8: Bit 1 selects code flash programming mode
// R9: Bit 3 inhibits code erase and program
// R10: Software holds inhibit low during code operations
// R11: Start bit launches selected sequencer command
// R12: End address 20 bits, upper nibble zero
// R13: Code programming ignores two low address bits
module fspr_regif
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // CPU register port
  input fspr_pkg::fspr_cpu_req_t cpuReq,
  output logic [15:0] cpuRdata,
  // Sequencer status
  input wire logic main_seq_end_flag,
  input wire logic extra_seq_end_flag,
  input wire logic sequencer_soft_reset_bit,
  input wire logic seqFinished,
  // Sequencer command and programming controls
  output fspr_pkg::fspr_seq_cmd_t seqCmd,
  output logic seqLaunch,
  output fspr_pkg::fspr_prog_t progCtrl
);
  import fspr_pkg::*;

  // ***********************************************
  // Storage
  // ***********************************************
  logic [7:0] program_mode_ctrl_reg;
  logic [7:0] seq_control_reg;
  logic [15:0] end_addr_low_reg;
  logic [`FSPR_END_HIGH_MSB:0] end_addr_high_reg;
  logic [15:0] writeBuf [2];
  fspr_seq_state_t seqState;
  fspr_seq_state_t next_seqState;
  logic progModeOpen;
  logic seqStopped;
  logic bufClear;
  logic [19:0] wordAddr;
  logic [19:0] alignedEnd;
  logic [15:0] readWord;
  logic [15:0] next_cpuRdata;
  logic modeWrite;
  logic seqWrite;
  logic endLowWrite;
  logic endHighWrite;
  logic [7:0] byteData;
  logic startRequest;

  // ***********************************************
  // Decode
  // ***********************************************
  assign progModeOpen = program_mode_ctrl_reg[`FSPR_MODE_CODE_BIT]
    | program_mode_ctrl_reg[`FSPR_MODE_DATA_BIT]; // R1
  assign seqStopped = ~main_seq_end_flag & ~extra_seq_end_flag;
  assign bufClear = sequencer_soft_reset_bit | seqFinished; // R4
  assign wordAddr = {cpuReq.addr[19:1], 1'b0};
  // Odd byte access carries its data in the high lane
  assign byteData = cpuReq.addr[0] ? cpuReq.wdata[15:8] : cpuReq.wdata[7:0];

  assign modeWrite = cpuReq.wr & ~cpuReq.word
    & (cpuReq.addr == `FSPR_ADDR_MODE_CTRL) & seqStopped;
  assign seqWrite = cpuReq.wr & ~cpuReq.word & (cpuReq.addr == `FSPR_ADDR_SEQ_CTRL);
  assign endLowWrite = cpuReq.wr & cpuReq.word
    & (cpuReq.addr == `FSPR_ADDR_END_LOW) & progModeOpen; // R1
  assign endHighWrite = cpuReq.wr & ~cpuReq.word
    & (cpuReq.addr == `FSPR_ADDR_END_HIGH) & progModeOpen; // R1
  assign startRequest = seqWrite & byteData[`FSPR_SEQ_START_BIT]
    & (seqState == FSPR_SEQ_IDLE); // R11

  // ***********************************************
  // Mode control register
  // ***********************************************
  // Changing modes under a running sequencer would corrupt the operation
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      program_mode_ctrl_reg <= `FSPR_RST_MODE_CTRL;
    end
    else if (modeWrite)
    begin
      program_mode_ctrl_reg <= byteData & `FSPR_MODE_WR_MASK; // R7 R8 R9
    end
  end

  // ***********************************************
  // Sequencer control register
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sequencer_soft_reset_bit)
    begin
      seq_control_reg <= `FSPR_RST_SEQ_CTRL;
    end
    else if (seqWrite && seqState == FSPR_SEQ_IDLE)
    begin
      seq_control_reg <= byteData & `FSPR_SEQ_WR_MASK; // R11
    end
    else
    begin
      // Finish must drop start even under a same-cycle stop write
      if (seqWrite)
      begin
        seq_control_reg[`FSPR_SEQ_STOP_BIT] <= byteData[`FSPR_SEQ_STOP_BIT];
      end
      if (seqFinished)
      begin
        seq_control_reg[`FSPR_SEQ_START_BIT] <= 1'b0;
        seq_control_reg[`FSPR_SEQ_STOP_BIT] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    next_seqState = seqState;
    case (seqState)
      FSPR_SEQ_IDLE:
      begin
        if (startRequest)
        begin
          next_seqState = FSPR_SEQ_BUSY; // R11
        end
      end
      FSPR_SEQ_BUSY:
      begin
        if (seqFinished)
        begin
          next_seqState = FSPR_SEQ_IDLE;
        end
      end
      default:
      begin
        next_seqState = FSPR_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sequencer_soft_reset_bit)
    begin
      seqState <= FSPR_SEQ_IDLE;
    end
    else
    begin
      seqState <= next_seqState;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sequencer_soft_reset_bit)
    begin
      seqLaunch <= 1'b0;
    end
    else
    begin
      seqLaunch <= startRequest; // R11
    end
  end

  assign seqCmd.start = seq_control_reg[`FSPR_SEQ_START_BIT];
  assign seqCmd.stop = seq_control_reg[`FSPR_SEQ_STOP_BIT];
  assign seqCmd.area = seq_control_reg[`FSPR_SEQ_AREA_BIT];
  assign seqCmd.cmd = seq_control_reg[`FSPR_SEQ_CMD_MSB:0];

  // ***********************************************
  // End address pointer
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      end_addr_low_reg <= `FSPR_RST_END_LOW;
    end
    else if (endLowWrite)
    begin
      end_addr_low_reg <= cpuReq.wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      end_addr_high_reg <= `FSPR_RST_END_HIGH;
    end
    else if (endHighWrite)
    begin
      end_addr_high_reg <= byteData[`FSPR_END_HIGH_MSB:0]; // R12
    end
  end

  // ***********************************************
  // Write data buffer, index 0 low, 1 high
  // ***********************************************
  for (genvar h = 0; h < 2; h++)
  begin : gen_wbuf
    logic halfWrite;
    assign halfWrite = cpuReq.wr & cpuReq.word & progModeOpen // R1 R3
      & (cpuReq.addr == (h == 0 ? `FSPR_ADDR_WBUF_LOW : `FSPR_ADDR_WBUF_HIGH));
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst || bufClear)
      begin
        writeBuf[h] <= `FSPR_RST_WBUF; // R4
      end
      else if (halfWrite)
      begin
        writeBuf[h] <= cpuReq.wdata;
      end
    end
  end

  // ***********************************************
  // Programming controls
  // ***********************************************
  // Inhibit gates only the code area; data area follows its own select
  assign progCtrl.codeProgEnable = program_mode_ctrl_reg[`FSPR_MODE_CODE_BIT]
    & ~program_mode_ctrl_reg[`FSPR_MODE_INHIBIT_BIT]; // R8 R9
  assign progCtrl.dataProgEnable = program_mode_ctrl_reg[`FSPR_MODE_DATA_BIT]; // R7
  assign progCtrl.progData = {writeBuf[1], writeBuf[0]}; // R6
  always_comb
  begin
    alignedEnd = {end_addr_high_reg, end_addr_low_reg}; // R12
    if (program_mode_ctrl_reg[`FSPR_MODE_CODE_BIT])
    begin
      alignedEnd[`FSPR_CODE_ALIGN_BITS-1:0] = '0; // R13
    end
  end
  assign progCtrl.endAddr = alignedEnd;

  // ***********************************************
  // Read path
  // ***********************************************
  always_comb
  begin
    case (wordAddr)
      `FSPR_ADDR_MODE_CTRL: readWord = {8'h00, program_mode_ctrl_reg};
      {`FSPR_ADDR_SEQ_CTRL} & 20'hffffe: readWord = {seq_control_reg, 8'h00};
      `FSPR_ADDR_END_LOW: readWord = end_addr_low_reg;
      `FSPR_ADDR_END_HIGH: readWord = {12'h000, end_addr_high_reg}; // R12
      `FSPR_ADDR_WBUF_LOW: readWord = writeBuf[0];
      `FSPR_ADDR_WBUF_HIGH: readWord = writeBuf[1];
      default: readWord = 16'h0000;
    endcase
    next_cpuRdata = readWord;
    if (!cpuReq.word)
    begin
      next_cpuRdata = {8'h00, cpuReq.addr[0] ? readWord[15:8] : readWord[7:0]};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cpuRdata <= 16'h0000;
    end
    else if (cpuReq.rd)
    begin
      cpuRdata <= next_cpuRdata;
    end
  end

endmodule // fspr_regif

// *** bench/fspr_regif_chk.sv ***
`timescale 1ns/100ps
`include "fspr_consts.svh"
// ****
// Port checker
// ****
module fspr_regif_chk
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched ports
  input fspr_pkg::fspr_cpu_req_t cpuReq,
  input wire logic [15:0] cpuRdata,
  input wire logic main_seq_end_flag,
  input wire logic extra_seq_end_flag,
  input wire logic sequencer_soft_reset_bit,
  input wire logic seqFinished,
  input fspr_pkg::fspr_seq_cmd_t seqCmd,
  input wire logic seqLaunch,
  input fspr_pkg::fspr_prog_t progCtrl
);
  import fspr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Clears win over a same-cycle write
  wire logic quiet = !sequencer_soft_reset_bit && !seqFinished;
  wire logic byteWr = cpuReq.wr && !cpuReq.word;
  wire logic modeWr = byteWr && cpuReq.addr == `FSPR_ADDR_MODE_CTRL &&
    !main_seq_end_flag && !extra_seq_end_flag;
  property p_clr_soft;
    sequencer_soft_reset_bit |=> progCtrl.progData == 32'h0;
  endproperty
  a_clr_soft: assert property (p_clr_soft)
    else $error("buffer kept after soft reset");
  property p_clr_fin;
    seqFinished |=> progCtrl.progData == 32'h0;
  endproperty
  a_clr_fin: assert property (p_clr_fin)
    else $error("buffer kept after finish");
  property p_launch;
    byteWr && cpuReq.addr == `FSPR_ADDR_SEQ_CTRL && cpuReq.wdata[15] && !seqCmd.start && quiet
      |=> seqLaunch && seqCmd.start;
  endproperty
  a_launch: assert property (p_launch)
    else $error("start write did not launch");
  property p_pulse;
    seqLaunch |=> !seqLaunch;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("launch longer than one cycle");
  property p_nibble;
    cpuReq.rd && !cpuReq.word && cpuReq.addr == `FSPR_ADDR_END_HIGH |=> cpuRdata[7:4] == 4'h0;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("end address upper nibble not zero");
  property p_align;
    progCtrl.codeProgEnable |-> progCtrl.endAddr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("code end address not word aligned");
  property p_byte_buf;
    byteWr && cpuReq.addr == `FSPR_ADDR_WBUF_LOW && quiet |=> $stable(progCtrl.progData);
  endproperty
  a_byte_buf: assert property (p_byte_buf)
    else $error("byte write reached buffer");
  property p_data_mode;
    modeWr |=> progCtrl.dataProgEnable == $past(cpuReq.wdata[4]);
  endproperty
  a_data_mode: assert property (p_data_mode)
    else $error("data mode bit wrong");
  property p_code_mode;
    modeWr |=> progCtrl.codeProgEnable == ($past(cpuReq.wdata[1]) && !$past(cpuReq.wdata[3]));
  endproperty
  a_code_mode: assert property (p_code_mode)
    else $error("code mode enable wrong");
  property p_high_half;
    cpuReq.wr && cpuReq.word && cpuReq.addr == `FSPR_ADDR_WBUF_HIGH && progCtrl.dataProgEnable
      && quiet |=> progCtrl.progData[31:16] == $past(cpuReq.wdata);
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("high half not in bits 31-16");
  c_launch: cover property (seqLaunch);
  c_fin: cover property (seqFinished);
  c_code: cover property (progCtrl.codeProgEnable);
endmodule // fspr_regif_chk

// *** bench/fspr_regif_bench.sv ***
`timescale 1ns/100ps
`include "fspr_consts.svh"
module fspr_regif_bench;
  import fspr_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  fspr_cpu_req_t cpuReq = '0;
  logic extraEnd = 1'b0;
  logic mainEnd = 1'b0;
  logic softRst = 1'b0;
  logic seqFin = 1'b0;
  logic [15:0] cpuRdata;
  fspr_seq_cmd_t seqCmd;
  logic seqLaunch;
  fspr_prog_t progCtrl;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] modes [4] = '{8'h02, 8'h0a, 8'h10, 8'h12};
  always #50 sys_clk = ~sys_clk;
  fspr_regif i_fspr_regif (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpuReq(cpuReq),
    .cpuRdata(cpuRdata), .main_seq_end_flag(mainEnd), .extra_seq_end_flag(extraEnd),
    .sequencer_soft_reset_bit(softRst), .seqFinished(seqFin), .seqCmd(seqCmd),
    .seqLaunch(seqLaunch), .progCtrl(progCtrl));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle cycle between accesses keeps each strobe a single pulse
  task automatic acc(input logic wr, input logic word, input logic [19:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1 cpuReq = '{wr, !wr, word, a, d};
    @(posedge sys_clk);
    #1 cpuReq = '0;
  endtask
  task automatic rd(input string what, input logic word, input logic [19:0] a, input logic [15:0] e);
    acc(1'b0, word, a, 16'h0);
    check(what, {16'h0, e}, {16'h0, cpuRdata});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd("mode", 1'b0, `FSPR_ADDR_MODE_CTRL, 16'h0008);
    rd("endLow", 1'b1, `FSPR_ADDR_END_LOW, 16'h0);
    rd("endHigh", 1'b0, `FSPR_ADDR_END_HIGH, 16'h0);
    rd("wbufHigh", 1'b1, `FSPR_ADDR_WBUF_HIGH, 16'h0);
    rd("unmapped", 1'b1, 20'hf02d0, 16'h0);
  endtask
  task automatic t_locked;
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_LOW, 16'h5a5a);
    acc(1'b1, 1'b1, `FSPR_ADDR_END_LOW, 16'h5a5a);
    rd("wbufLow", 1'b1, `FSPR_ADDR_WBUF_LOW, 16'h0);
    rd("endLow", 1'b1, `FSPR_ADDR_END_LOW, 16'h0);
  endtask
  task automatic t_modes;
    foreach (modes[i])
    begin
      acc(1'b1, 1'b0, `FSPR_ADDR_MODE_CTRL, {8'h0, modes[i]});
      check("dataEn", modes[i][4], progCtrl.dataProgEnable);
      check("codeEn", modes[i][1] & ~modes[i][3], progCtrl.codeProgEnable);
    end
    extraEnd = 1'b1;
    acc(1'b1, 1'b0, `FSPR_ADDR_MODE_CTRL, 16'h0);
    extraEnd = 1'b0;
    check("dataKept", 1'b1, progCtrl.dataProgEnable);
    mainEnd = 1'b1;
    acc(1'b1, 1'b0, `FSPR_ADDR_MODE_CTRL, 16'h0);
    mainEnd = 1'b0;
    check("dataKeptMain", 1'b1, progCtrl.dataProgEnable);
  endtask
  task automatic t_data;
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_LOW, 16'h1234);
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_HIGH, 16'habcd);
    acc(1'b1, 1'b0, `FSPR_ADDR_WBUF_LOW, 16'h0055);
    check("progData", 32'habcd1234, progCtrl.progData);
    rd("wbufHigh", 1'b1, `FSPR_ADDR_WBUF_HIGH, 16'habcd);
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_HIGH, 16'h0000);
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_LOW, 16'h00a5);
    check("dataByte", 32'h000000a5, progCtrl.progData);
  endtask
  task automatic t_end;
    acc(1'b1, 1'b0, `FSPR_ADDR_END_HIGH, 16'h00ff);
    acc(1'b1, 1'b1, `FSPR_ADDR_END_LOW, 16'hffff);
    check("endAddr", 20'hffffc, progCtrl.endAddr);
    rd("endHigh", 1'b0, `FSPR_ADDR_END_HIGH, 16'h000f);
    acc(1'b1, 1'b0, `FSPR_ADDR_MODE_CTRL, 16'h0010);
    check("endAddr", 20'hfffff, progCtrl.endAddr);
  endtask
  task automatic t_seq;
    acc(1'b1, 1'b0, `FSPR_ADDR_MODE_CTRL, 16'h0002);
    acc(1'b1, 1'b0, `FSPR_ADDR_SEQ_CTRL, 16'h8300);
    check("launch", 1'b1, seqLaunch);
    check("seqCmd", 6'h23, seqCmd);
    @(posedge sys_clk);
    #1 seqFin = 1'b1;
    check("launch", 1'b0, seqLaunch);
    @(posedge sys_clk);
    #1 seqFin = 1'b0;
    check("progData", 32'h0, progCtrl.progData);
    check("start", 1'b0, seqCmd.start);
    check("codeEn", 1'b1, progCtrl.codeProgEnable);
    rd("seqCtrl", 1'b0, `FSPR_ADDR_SEQ_CTRL, 16'h0003);
  endtask
  task automatic t_soft;
    acc(1'b1, 1'b1, `FSPR_ADDR_WBUF_HIGH, 16'h7777);
    check("progData", 32'h77770000, progCtrl.progData);
    softRst = 1'b1;
    @(posedge sys_clk);
    #1 softRst = 1'b0;
    check("progData", 32'h0, progCtrl.progData);
    check("seqCmd", 6'h00, seqCmd);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_reset;
    t_locked;
    t_modes;
    t_data;
    t_end;
    t_seq;
    t_soft;
    give_verdict;
  end
  // Run needs under 80 cycles
  initial
  begin
    #100000;
    mismatches++;
    give_verdict;
  end
endmodule // fspr_regif_bench
bind fspr_regif fspr_regif_chk i_fspr_regif_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .cpuReq(cpuReq), .cpuRdata(cpuRdata), .main_seq_end_flag(main_seq_end_flag),
  .extra_seq_end_flag(extra_seq_end_flag), .sequencer_soft_reset_bit(sequencer_soft_reset_bit),
  .seqFinished(seqFinished), .seqCmd(seqCmd), .seqLaunch(seqLaunch), .progCtrl(progCtrl));
